// file: rtl/rra_arbiter.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

module rra_arbiter
  import rra_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = LINK_TIMEOUT_CYCLES,
  parameter int SCAN_CYCLES = SCAN_PERIOD_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ab_select_b,
  input wire logic rx_link_ok,
  input wire rra_msg_t rx_msg,
  input wire logic erio_link_ok,
  input wire logic erio_peer_active,
  input wire logic erio_peer_primary,
  input wire logic adapter_ok,
  output rra_msg_t tx_msg,
  output logic tx_valid,
  output rra_role_t role
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int SW = $clog2(SCAN_CYCLES + 1);
  localparam logic [TW-1:0] TIMEOUT_MAX = TW'(TIMEOUT_CYCLES);
  localparam logic [SW-1:0] SCAN_LAST = SW'(SCAN_CYCLES - 1);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  localparam int PW = $bits(rra_msg_t) + 6;

  logic [PW-1:0] pins_sync;
  logic is_b;
  logic rx_ok;
  rra_msg_t peer;
  logic erio_ok;
  logic peer_active;
  logic peer_primary;
  logic adapters;

  rra_sync #(
    .W(PW)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({ab_select_b, rx_link_ok, rx_msg, erio_link_ok, erio_peer_active,
        erio_peer_primary, adapter_ok}),
    .q(pins_sync)
  );

  assign {is_b, rx_ok, peer, erio_ok, peer_active, peer_primary, adapters} = pins_sync;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] status;
  logic wr_take;
  logic rd_take;

  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_take;

  function automatic logic [31:0] merge_bytes(logic [31:0] old, logic [31:0] data,
                                               logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wr_take && s_axi_awaddr == CTRL_ADDR)
    begin
      ctrl <= merge_bytes(ctrl, s_axi_wdata, s_axi_wstrb) & CTRL_MASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_take)
    begin
      s_axi_bvalid <= 1'b1;
      if (s_axi_awaddr == CTRL_ADDR || s_axi_awaddr == STATUS_ADDR)
      begin
        s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == CTRL_ADDR)
      begin
        s_axi_rdata <= ctrl;
        s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_araddr == STATUS_ADDR)
      begin
        s_axi_rdata <= status;
        s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Standby permission
  // ---------------------------------------------------------------
  logic fw_ok;
  logic logic_ok;
  logic safe_ok;
  logic allowed;

  assign fw_ok = !ctrl[CTRL_FW_DIFF] || ctrl[CTRL_FW_PERMIT];
  assign logic_ok = !ctrl[CTRL_LOGIC_DIFF]
                    || (ctrl[CTRL_LOGIC_PERMIT] && ctrl[CTRL_ONLINE_MOD]);
  assign safe_ok = !(ctrl[CTRL_SAFETY] && ctrl[CTRL_LOGIC_DIFF] && ctrl[CTRL_SAFE_DIFF])
                   || ctrl[CTRL_MAINT];
  assign allowed = fw_ok && logic_ok && safe_ok;

  // ---------------------------------------------------------------
  // Scan tick and link timeout
  // ---------------------------------------------------------------
  rra_state_t state;
  rra_state_t next_state;
  logic [SW-1:0] scan_cnt;
  logic scan_tick;
  logic [TW-1:0] lost_cnt;
  logic lost;
  logic restart_scan;

  // Restart so that a listen or hand-off phase spans a full scan
  assign restart_scan = (next_state != state)
                        && (next_state == ST_LISTEN || next_state == ST_HANDOFF);
  assign scan_tick = (scan_cnt == SCAN_LAST);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scan_cnt <= '0;
    end
    else if (restart_scan || scan_tick)
    begin
      scan_cnt <= '0;
    end
    else
    begin
      scan_cnt <= scan_cnt + SW'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lost_cnt <= '0;
    end
    else if (rx_ok)
    begin
      lost_cnt <= '0;
    end
    else if (lost_cnt != TIMEOUT_MAX)
    begin
      lost_cnt <= lost_cnt + TW'(1);
    end
  end

  assign lost = (lost_cnt == TIMEOUT_MAX);

  // ---------------------------------------------------------------
  // Role arbitration
  // ---------------------------------------------------------------
  logic peer_is_primary;
  logic peer_started;

  assign peer_is_primary = rx_ok && peer.role == MSG_PRIMARY;
  assign peer_started = rx_ok ? (peer.role != MSG_OFF) : peer_active;

  always_comb
  begin
    next_state = state;
    if (!ctrl[CTRL_RUN])
    begin
      next_state = ST_OFF;
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          next_state = ST_LISTEN;
        end
        ST_LISTEN:
        begin
          if (scan_tick)
          begin
            if (peer_is_primary)
            begin
              next_state = allowed ? ST_STANDBY : ST_WAIT;
            end
            else if (!rx_ok && (peer_primary || (peer_active && is_b)))
            begin
              next_state = ST_WAIT;
            end
            else if (rx_ok && peer_active && peer.role == MSG_OFF && is_b)
            begin
              next_state = allowed ? ST_STANDBY : ST_WAIT;
            end
            else
            begin
              next_state = ST_PRIMARY;
            end
          end
        end
        ST_PRIMARY:
        begin
          if (is_b && peer_is_primary)
          begin
            // Wait role for a full scan before any later standby
            next_state = ST_HANDOFF;
          end
          else if (!adapters && rx_ok && peer.role == MSG_STANDBY && peer.adapter_ok
                   && allowed)
          begin
            next_state = ST_HANDOFF;
          end
        end
        ST_HANDOFF:
        begin
          if (scan_tick)
          begin
            next_state = allowed ? ST_STANDBY : ST_WAIT;
          end
        end
        ST_STANDBY:
        begin
          if (!allowed)
          begin
            next_state = ST_WAIT;
          end
          else if (lost && erio_ok)
          begin
            next_state = ST_WAIT;
          end
          else if (lost && !erio_ok)
          begin
            next_state = ST_PRIMARY;
          end
          else if (rx_ok && peer.role == MSG_WAIT)
          begin
            next_state = ST_PRIMARY;
          end
          // One-way break toward the peer keeps standby
        end
        ST_WAIT:
        begin
          if (peer_is_primary && allowed)
          begin
            next_state = ST_STANDBY;
          end
        end
        default:
        begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_OFF;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Role outputs and link message
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      role <= '0;
      tx_msg <= '0;
      tx_valid <= 1'b0;
    end
    else
    begin
      role.primary <= (next_state == ST_PRIMARY);
      role.standby <= (next_state == ST_STANDBY);
      role.wait_state <= (next_state == ST_WAIT || next_state == ST_HANDOFF);
      tx_valid <= (next_state != ST_OFF);
      tx_msg.adapter_ok <= adapters;
      case (next_state)
        ST_PRIMARY:
        begin
          tx_msg.role <= MSG_PRIMARY;
        end
        ST_STANDBY:
        begin
          tx_msg.role <= MSG_STANDBY;
        end
        ST_WAIT, ST_HANDOFF:
        begin
          tx_msg.role <= MSG_WAIT;
        end
        default:
        begin
          tx_msg.role <= MSG_OFF;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  always_comb
  begin
    status = 32'h00000000;
    status[ST_PRIMARY_BIT] = role.primary;
    status[ST_STANDBY_BIT] = role.standby;
    status[ST_WAIT_BIT] = role.wait_state;
    status[ST_IS_B_BIT] = is_b;
    status[ST_RX_OK_BIT] = rx_ok;
    status[ST_ERIO_OK_BIT] = erio_ok;
    status[ST_ADAPTER_BIT] = adapters;
    status[ST_PEER_ROLE_LO +: 2] = peer.role;
    status[ST_ALLOWED_BIT] = allowed;
    status[ST_LOST_BIT] = lost;
  end

endmodule

// file: rtl/rra_pkg.sv
package rra_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int LINK_TIMEOUT_MS = 3000;
  localparam int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_MS * CLK_PER_MS;
  localparam int SCAN_PERIOD_CYCLES = 250;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h000001ff;

  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_FW_PERMIT = 1;
  localparam int CTRL_LOGIC_PERMIT = 2;
  localparam int CTRL_ONLINE_MOD = 3;
  localparam int CTRL_MAINT = 4;
  localparam int CTRL_SAFETY = 5;
  localparam int CTRL_FW_DIFF = 6;
  localparam int CTRL_LOGIC_DIFF = 7;
  localparam int CTRL_SAFE_DIFF = 8;

  // Status fields
  localparam int ST_PRIMARY_BIT = 0;
  localparam int ST_STANDBY_BIT = 1;
  localparam int ST_WAIT_BIT = 2;
  localparam int ST_IS_B_BIT = 3;
  localparam int ST_RX_OK_BIT = 4;
  localparam int ST_ERIO_OK_BIT = 5;
  localparam int ST_ADAPTER_BIT = 6;
  localparam int ST_PEER_ROLE_LO = 8;
  localparam int ST_ALLOWED_BIT = 10;
  localparam int ST_LOST_BIT = 11;

  // ---------------------------------------------------------------
  // AXI responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Link message role codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MSG_OFF = 2'h0;
  localparam logic [1:0] MSG_PRIMARY = 2'h1;
  localparam logic [1:0] MSG_STANDBY = 2'h2;
  localparam logic [1:0] MSG_WAIT = 2'h3;

  typedef struct packed {
    logic [1:0] role;
    logic adapter_ok;
  } rra_msg_t;

  typedef struct packed {
    logic primary;
    logic standby;
    logic wait_state;
  } rra_role_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LISTEN,
    ST_PRIMARY,
    ST_STANDBY,
    ST_WAIT,
    ST_HANDOFF
  } rra_state_t;

endpackage

// file: rtl/rra_sync.sv
`timescale 1ns/100ps

module rra_sync
  import rra_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic [W-1:0] meta;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// file: test/rra_peer.sv
`timescale 1ns/100ps

module rra_peer
  import rra_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] peer_role,
  input wire logic peer_run,
  input wire logic link_up,
  input wire logic ring_up,
  output rra_msg_t rx_msg,
  output logic rx_link_ok,
  output logic erio_link_ok,
  output logic erio_peer_active,
  output logic erio_peer_primary
);
  // ----
  // Counterpart controller
  // ----
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_msg <= '0;
      rx_link_ok <= 1'b0;
      erio_link_ok <= 1'b0;
      erio_peer_active <= 1'b0;
      erio_peer_primary <= 1'b0;
    end
    else
    begin
      rx_link_ok <= link_up;
      // Dead link shows a toggling pattern
      rx_msg <= link_up ? {peer_run ? peer_role : MSG_OFF, 1'b1} : ~rx_msg;
      erio_link_ok <= ring_up;
      erio_peer_active <= ring_up & peer_run;
      erio_peer_primary <= ring_up & peer_run & (peer_role == MSG_PRIMARY);
    end
  end
endmodule

// file: test/rra_props.sv
`timescale 1ns/100ps

module rra_props
  import rra_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 40,
  parameter int SCAN_CYCLES = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_link_ok,
  input wire rra_msg_t tx_msg,
  input wire logic tx_valid,
  input wire rra_role_t role
);
  // ----
  // Role checks
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int lost_cnt;

  // Consecutive cycles without the incoming link
  always_ff @(posedge aclk)
  begin
    if (!aresetn || rx_link_ok)
      lost_cnt <= 0;
    else if (lost_cnt < TIMEOUT_CYCLES)
      lost_cnt <= lost_cnt + 1;
  end

  a_role_onehot: assert property ($onehot0(role))
    else $error("role not one-hot");
  a_stop_quiet: assert property (!tx_valid |-> role == 3'h0)
    else $error("role while stopped");
  a_live_send: assert property (role != 3'h0 |-> tx_valid)
    else $error("role not sent");
  a_tx_code: assert property (tx_valid |-> tx_msg.role == (role.primary ? MSG_PRIMARY :
    role.standby ? MSG_STANDBY : role.wait_state ? MSG_WAIT : MSG_OFF))
    else $error("sent role code wrong");
  a_no_skip: assert property (role.primary |=> !role.standby)
    else $error("primary went straight to standby");
  a_handoff_hold: assert property ($rose(role.wait_state) && $past(role.primary)
    |-> role.wait_state [*8])
    else $error("hand-off wait too short");
  a_listen_quiet: assert property ($rose(tx_valid) |-> (role == 3'h0) [*4])
    else $error("role before listen ended");
  a_wait_late: assert property (role.standby ##1 role.wait_state
    |-> lost_cnt >= TIMEOUT_CYCLES)
    else $error("standby left early");
  c_primary: cover property (role.primary);
  c_standby: cover property (role.standby);
  c_handoff: cover property ($past(role.primary) && role.wait_state);
endmodule

bind rra_arbiter rra_props #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .SCAN_CYCLES(SCAN_CYCLES)
) rra_props_inst (
  .aclk(aclk),
  .aresetn(aresetn),
  .rx_link_ok(rx_link_ok),
  .tx_msg(tx_msg),
  .tx_valid(tx_valid),
  .role(role)
);

// file: test/testbench.sv
`timescale 1ns/100ps

module testbench
  import rra_pkg::*;
;
  localparam int TO = 40;
  localparam rra_role_t RP = 3'b100;
  localparam rra_role_t RS = 3'b010;
  localparam rra_role_t RW = 3'b001;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] aw = 4'h0, ar = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr, bv, arr, rv, rx_ok, e_ok, e_act, e_pri, txv;
  logic [1:0] br, rr, resp;
  logic [31:0] wd = 32'h0, rd, data;
  logic sel_b = 1'b0, adp = 1'b1, p_run = 1'b0, p_link = 1'b1, p_ring = 1'b1;
  logic [1:0] p_role = 2'h0;
  rra_msg_t rx_m, tx_m;
  rra_role_t role;
  int error_cnt = 0, compares = 0;

  rra_arbiter #(.TIMEOUT_CYCLES(TO), .SCAN_CYCLES(8)) rra_arbiter_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .ab_select_b(sel_b), .rx_link_ok(rx_ok), .rx_msg(rx_m), .erio_link_ok(e_ok),
    .erio_peer_active(e_act), .erio_peer_primary(e_pri), .adapter_ok(adp),
    .tx_msg(tx_m), .tx_valid(txv), .role(role));

  rra_peer rra_peer_inst (
    .aclk(aclk), .aresetn(aresetn), .peer_role(p_role), .peer_run(p_run),
    .link_up(p_link), .ring_up(p_ring), .rx_msg(rx_m), .rx_link_ok(rx_ok),
    .erio_link_ok(e_ok), .erio_peer_active(e_act), .erio_peer_primary(e_pri));

  always #20 aclk = ~aclk;

  // ----
  // Shared tasks
  // ----
  task automatic results();
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wt(input int k, input rra_role_t e);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (n < 300 && (k == 0 ? awr : k == 1 ? bv : k == 2 ? arr : k == 3 ? rv :
      role === e) !== 1'b1);
    if (n >= 300)
    begin
      error_cnt++;
      $display("[ERR] %0t wait %h %h", $time, k, e);
      results();
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    wt(0, RP);
    @(posedge aclk);
    awv <= 1'b0;
    wv <= 1'b0;
    wt(1, RP);
    resp = br;
    @(posedge aclk);
    brdy <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    wt(2, RP);
    @(posedge aclk);
    arv <= 1'b0;
    wt(3, RP);
    data = rd;
    resp = rr;
    @(posedge aclk);
    rrdy <= 1'b0;
  endtask

  // Pins are {select B, peer running, peer role, link up}
  task automatic start_case(input logic [8:0] c, input logic [4:0] pins, input rra_role_t e);
    wr_reg(CTRL_ADDR, 32'h0);
    @(posedge aclk);
    {sel_b, p_run, p_role, p_link} <= pins;
    repeat (4) @(posedge aclk);
    wr_reg(CTRL_ADDR, {23'h0, c} | 32'h1);
    wt(4, e);
    // Role must settle, not just pass through
    repeat (10) @(negedge aclk);
    chk(role, e);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd_reg(CTRL_ADDR);
    chk({resp, data}, {RESP_OKAY, CTRL_RESET});
    rd_reg(4'h8);
    chk({resp, data}, {RESP_SLVERR, 32'h0});
    // Stopped, link and ring up, adapters seen, standby allowed
    rd_reg(STATUS_ADDR);
    chk({resp, data}, {RESP_OKAY, 32'h00000470});
    wr_reg(4'hc, 32'h1);
    chk({resp, txv}, {RESP_SLVERR, 1'b0});
    wr_reg(CTRL_ADDR, 32'hffffffff);
    rd_reg(CTRL_ADDR);
    chk(data, CTRL_MASK);
    $display("regs done");
  endtask

  task automatic t_starts();
    logic [8:0] ct[11] = '{9'h0, 9'h42, 9'h0, 9'h0, 9'h0, 9'h0, 9'h40, 9'h84, 9'h8c,
      9'h1ac, 9'h1bc};
    logic [4:0] pn[11] = '{5'h01, 5'h0b, 5'h19, 5'h09, 5'h18, 5'h1a, 5'h0b, 5'h0b,
      5'h0b, 5'h0b, 5'h0b};
    rra_role_t ex[11] = '{RP, RS, RS, RP, RW, RW, RW, RW, RS, RW, RS};
    for (int i = 0; i < 11; i++)
      start_case(ct[i], pn[i], ex[i]);
    $display("starts done");
  endtask

  task automatic t_run();
    start_case(9'h0, 5'h01, RP);
    chk(tx_m, {MSG_PRIMARY, 1'b1});
    @(posedge aclk);
    {p_run, p_role} <= {1'b1, MSG_WAIT};
    repeat (TO + 10) @(posedge aclk);
    chk(role, RP);
    p_link <= 1'b0;
    repeat (TO + 10) @(posedge aclk);
    chk(role, RP);
    {p_link, p_role} <= {1'b1, MSG_STANDBY};
    repeat (4) @(posedge aclk);
    adp <= 1'b0;
    wt(4, RW);
    chk(role, RW);
    chk(tx_m, {MSG_WAIT, 1'b0});
    wt(4, RS);
    chk(role, RS);
    @(posedge aclk);
    adp <= 1'b1;
    start_case(9'h0, 5'h0b, RS);
    repeat (TO + 10) @(posedge aclk);
    chk(role, RS);
    p_link <= 1'b0;
    repeat (TO / 2) @(posedge aclk);
    chk(role, RS);
    wt(4, RW);
    chk(role, RW);
    $display("run done");
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({txv, role}, 4'h0);
    t_regs();
    t_starts();
    t_run();
    results();
  end
endmodule
